/* bench/sstm_host_model.sv */
/* host-side frame taker: acks each send request.
   assumes requests stay high until the ack is seen. */
`timescale 1ns/1ns
module sstm_host_model (
  input wire i_clk, // core clock
  input wire i_rst, // async reset, high
  input wire [3:0] i_dly, // cycles before ack, keep under 15
  input wire i_send_reg, // register frame request
  input wire i_send_pio, // setup frame request
  output reg o_ack // one-cycle ack
);
  reg [3:0] cnt_reg;
  wire req = i_send_reg || i_send_pio;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= 4'h0;
      o_ack <= 1'b0;
    end else begin
      // slow ack shows whether the design holds its request
      o_ack <= req && !o_ack && cnt_reg >= i_dly;
      cnt_reg <= (req && !o_ack) ? cnt_reg + 4'h1 : 4'h0;
    end
  end
endmodule // sstm_host_model

/* bench/sstm_monitor_assertions.sv */
/* checker for the status timeout monitor.
   bound to sstm_monitor; limits follow its parameters. */
`timescale 1ns/1ns
module sstm_monitor_assertions #(
  parameter int RESET_LIMIT = 200,
  parameter int CMD_LIMIT = 100
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_comreset,
  input wire i_srst_set,
  input wire i_cmd,
  input wire i_send_ack,
  input wire [7:0] o_status,
  input wire o_send_reg,
  input wire o_send_pio,
  input wire o_timeout
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_ready; o_send_reg && !o_status[7] && o_status[6]; endsequence
  sequence s_pio; o_send_pio && !o_status[7] && o_status[3]; endsequence
  // cycle counters stand in for delay ranges: real limits run to
  // hundreds of millions of cycles
  int unsigned rst_wait, cmd_wait;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_wait <= 0;
      cmd_wait <= 0;
    end else begin
      if (i_comreset) begin
        rst_wait <= 1;
      end else if (i_srst_set || (o_send_reg && !o_status[7] && o_status[6])) begin
        rst_wait <= 0;
      end else if (rst_wait != 0 && rst_wait <= RESET_LIMIT) begin
        rst_wait <= rst_wait + 1;
      end
      if (i_comreset || i_srst_set) begin
        cmd_wait <= 0;
      end else if (i_cmd && o_status == 8'h40 && !o_send_reg && !o_send_pio) begin
        cmd_wait <= 1;
      end else if ((o_send_reg && !o_status[7] && o_status[6]) || (o_send_pio && !o_status[7] && o_status[3])) begin
        cmd_wait <= 0;
      end else if (cmd_wait != 0 && cmd_wait <= CMD_LIMIT) begin
        cmd_wait <= cmd_wait + 1;
      end
    end
  end
  link_busy_a: assert property (i_comreset |=> o_status[7])
    else $error("no busy after link reset");
  link_ready_a: assert property (rst_wait <= RESET_LIMIT)
    else $error("link reset not answered in time");
  srst_busy_a: assert property (i_srst_set |=> o_status[7])
    else $error("no busy after soft reset");
  ready_status_a: assert property ($rose(o_send_reg) |-> !o_status[7] && o_status[6])
    else $error("register frame without ready");
  pio_status_a: assert property ($rose(o_send_pio) |-> s_pio)
    else $error("setup frame without data request");
  cmd_answer_a: assert property (cmd_wait <= CMD_LIMIT)
    else $error("command not answered in time");
  send_hold_a: assert property (o_send_pio && !i_send_ack |=> o_send_pio)
    else $error("setup request dropped before ack");
  forced_ans_a: assert property (o_timeout |-> (s_ready and o_status[0]))
    else $error("forced answer malformed");
endmodule // sstm_monitor_assertions
bind sstm_monitor sstm_monitor_assertions #(.RESET_LIMIT(RESET_LIMIT), .CMD_LIMIT(CMD_LIMIT)) chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_comreset(i_comreset), .i_srst_set(i_srst_set), .i_cmd(i_cmd),
  .i_send_ack(i_send_ack), .o_status(o_status), .o_send_reg(o_send_reg), .o_send_pio(o_send_pio),
  .o_timeout(o_timeout));

/* bench/tb.sv */
/* testbench for sstm_monitor with short limits.
   host model acks frames; bench plays the frame layer. */
`timescale 1ns/1ns
module tb;
  logic i_clk = 0, i_rst = 1, i_comreset = 0, i_srst_set = 0, i_srst_clr = 0;
  logic i_cmd = 0, i_data_fis = 0, i_be_ready = 0;
  logic [1:0] i_cmd_kind = 2'h0;
  logic [3:0] dly = 4'h1;
  wire [7:0] o_status;
  wire o_send_reg, o_send_pio, o_timeout, ack;
  int errors = 0, n_checks = 0;
  logic [2:0] rows [3] = '{3'h0, 3'h3, 3'h5}; // kind, pio answer
  always #20 i_clk = ~i_clk;
  sstm_monitor #(.RESET_LIMIT(200), .CMD_LIMIT(100), .MARGIN(16)) uut (.i_clk(i_clk), .i_rst(i_rst),
    .i_comreset(i_comreset), .i_srst_set(i_srst_set), .i_srst_clr(i_srst_clr), .i_cmd(i_cmd),
    .i_cmd_kind(i_cmd_kind), .i_data_fis(i_data_fis), .i_be_ready(i_be_ready), .i_send_ack(ack),
    .o_status(o_status), .o_send_reg(o_send_reg), .o_send_pio(o_send_pio), .o_timeout(o_timeout));
  sstm_host_model host (.i_clk(i_clk), .i_rst(i_rst), .i_dly(dly), .i_send_reg(o_send_reg),
    .i_send_pio(o_send_pio), .o_ack(ack));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t status %h want %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task pulse(input int w, input logic [1:0] kind);
    @(posedge i_clk);
    i_cmd_kind <= kind;
    case (w)
      0: i_comreset <= 1;
      1: i_srst_set <= 1;
      2: i_srst_clr <= 1;
      3: i_cmd <= 1;
      4: i_data_fis <= 1;
      default: i_be_ready <= 1;
    endcase
    @(posedge i_clk);
    {i_comreset, i_srst_set, i_srst_clr, i_cmd, i_data_fis, i_be_ready} <= 6'h00;
    #1;
  endtask
  task wait_for(input int w);
    int k;
    k = 0;
    while (k < 400 && (w == 0 ? o_send_reg : w == 1 ? o_send_pio : o_timeout) !== 1'b1) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    if (k == 400) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task settle;
    repeat (12) @(posedge i_clk);
    #1;
  endtask
  task link_reset;
    pulse(0, 2'h0);
    check(o_status, 8'h80);
    pulse(5, 2'h0);
    wait_for(0);
    check(o_status, 8'h40);
    check({7'h0, o_timeout}, 8'h00);
    settle();
  endtask
  task soft_reset;
    pulse(1, 2'h0);
    check({7'h0, o_status[7]}, 8'h01);
    pulse(2, 2'h0);
    pulse(5, 2'h0);
    wait_for(0);
    check(o_status, 8'h40);
    settle();
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    check(o_status, 8'h80);
    i_rst <= 0;
    // no back end answer: deadline must force the frame
    wait_for(2);
    check(o_status, 8'h41);
    check({7'h0, o_send_reg}, 8'h01);
    settle();
    link_reset();
    for (int r = 0; r < 3; r++) begin
      pulse(3, rows[r][2:1]);
      check(o_status, 8'h80);
      pulse(5, 2'h0);
      wait_for(rows[r][0]);
      check(rows[r][0] ? {7'h0, o_status[3]} : o_status, rows[r][0] ? 8'h01 : 8'h40);
      check({7'h0, o_status[7]}, 8'h00);
      settle();
      if (rows[r][2:1] == 2'h2) pulse(4, 2'h0);
      check({7'h0, o_status[7]}, {7'h0, rows[r][0]});
      link_reset();
    end
    dly <= 4'h5;
    soft_reset();
    pulse(3, 2'h0);
    wait_for(2);
    check(o_status, 8'h41);
    check({7'h0, o_send_reg}, 8'h01);
    settle();
    // host gives up: soft reset, then the same command again
    soft_reset();
    pulse(3, 2'h0);
    check(o_status, 8'h80);
    pulse(5, 2'h0);
    wait_for(0);
    check(o_status, 8'h40);
    check({7'h0, o_timeout}, 8'h00);
    settle();
    // second power-up in mid-run restarts the power-up deadline
    @(posedge i_clk);
    i_rst <= 1;
    repeat (3) @(posedge i_clk);
    i_rst <= 0;
    #1;
    check(o_status, 8'h80);
    check({5'h0, o_send_reg, o_send_pio, o_timeout}, 8'h00);
    wait_for(2);
    check(o_status, 8'h41);
    check({7'h0, o_send_reg}, 8'h01);
    settle();
    tally_and_finish();
  end
endmodule // tb

/* rtl/sstm_deadline.v */
/*
 * one-shot deadline counter: loads a limit on start, counts down,
 * pulses expiry once when it runs out, cleared by stop.
 * assumes start and stop are single-cycle pulses from the owner.
 */
`timescale 1ns/1ns
module sstm_deadline #(
  parameter W = 30
) (
  input wire i_clk, // core clock
  input wire i_rst, // async reset, high
  input wire i_start, // load limit and run
  input wire i_stop, // abandon count
  input wire [W-1:0] i_limit, // limit in cycles
  output reg o_running, // count in progress
  output reg o_expired // one-cycle expiry pulse
);
  reg [W-1:0] count_reg;

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= {W{1'b0}};
      o_running <= 1'b0;
      o_expired <= 1'b0;
    end else begin
      o_expired <= 1'b0;
      if (i_start) begin
        count_reg <= i_limit;
        o_running <= 1'b1;
      end else if (i_stop) begin
        o_running <= 1'b0;
      end else if (o_running) begin
        if (count_reg <= {{(W-1){1'b0}}, 1'b1}) begin
          // limit reached: the reply has still not come
          o_running <= 1'b0;
          o_expired <= 1'b1;
        end else begin
          count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // sstm_deadline

/* rtl/sstm_monitor.v */
/*
 * device-side busy/data-request sequencer with wall-clock deadlines.
 * after power-up, link reset, software reset and each command the
 * device answers before its limit; if the back end is slow, a forced
 * answer with the error bit set goes out at the deadline.
 * assumes the frame layer reports received frames as one-cycle pulses
 * and accepts one send request at a time with an ack pulse.
 */
`timescale 1ns/1ns
`include "sstm_consts.vh"
// How it works
// [R1] after power-up, ready register frame within 31 s
// [R2] after link reset, ready register frame within 31 s
// [R3] host shows busy within 400 ns after reset-set frame
// [R4] after reset-clear frame, ready frame within 31 s
// [R5] host shows busy within 400 ns of command frame
// [R6] non-data command completes within 30 s
// [R7] pio-in: data-request setup frame within 30 s
// [R8] host shows busy 400 ns after pio-in setup
// [R9] host shows busy 400 ns after data frame
// [R10] pio-out: data-request setup frame within 30 s
// [R11] host resets and retries after its timeout
// [R12] host flags timeouts; busy bit 7, request bit 3
module sstm_monitor #(
  parameter RESET_LIMIT = `SSTM_RESET_LIMIT_CYC, // power-up/reset answer limit
  parameter CMD_LIMIT = `SSTM_CMD_LIMIT_CYC, // command answer limit
  parameter MARGIN = 16 // cycles kept before the limit for the forced answer
) (
  input wire i_clk, // core clock 25 MHz
  input wire i_rst, // power-on reset, async high
  input wire i_comreset, // link reset seen, pulse
  input wire i_srst_set, // register frame with soft reset set, pulse
  input wire i_srst_clr, // register frame with soft reset cleared, pulse
  input wire i_cmd, // command register frame, pulse
  input wire [1:0] i_cmd_kind, // kind of command with i_cmd
  input wire i_data_fis, // data frame received, pulse
  input wire i_be_ready, // back end finished its work, pulse
  input wire i_send_ack, // frame layer took the send request, pulse
  output reg [7:0] o_status, // status byte of outgoing frame
  output reg o_send_reg, // send register frame, held until ack
  output reg o_send_pio, // send pio setup frame, held until ack
  output reg o_timeout // deadline forced an answer, pulse
);
  localparam ST_RESET = 3'h0;
  localparam ST_IDLE = 3'h1;
  localparam ST_SRST = 3'h2;
  localparam ST_WORK = 3'h3;
  localparam ST_SEND = 3'h4;
  localparam ST_XFER = 3'h5;

  reg [2:0] state_reg, state_next;
  reg [1:0] kind_reg, kind_next;
  reg [7:0] status_next;
  reg send_reg_next, send_pio_next, timeout_next;
  reg dl_start, dl_stop;
  reg [29:0] dl_limit;
  reg boot_reg;
  wire dl_expired;

  // ------------------------------------------------------------
  // deadline
  // ------------------------------------------------------------
  // the counter targets the limit minus a margin so the answer
  // is on the wire before the host's own clock runs out
  sstm_deadline #(.W(30)) u_deadline (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(dl_start),
    .i_stop(dl_stop),
    .i_limit(dl_limit),
    .o_running(),
    .o_expired(dl_expired)
  );

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    kind_next = kind_reg;
    status_next = o_status;
    send_reg_next = o_send_reg;
    send_pio_next = o_send_pio;
    timeout_next = 1'b0;
    dl_start = 1'b0;
    dl_stop = 1'b0;
    dl_limit = RESET_LIMIT[29:0] - MARGIN[29:0];
    if (boot_reg) begin
      // first cycle after power-up reset release
      dl_start = 1'b1; // [R1]
      state_next = ST_RESET;
    end else if (i_comreset) begin
      status_next = 8'h80;
      send_reg_next = 1'b0;
      send_pio_next = 1'b0;
      dl_start = 1'b1; // [R2]
      state_next = ST_RESET;
    end else if (i_srst_set) begin
      // host marks busy itself; device waits for the clear frame
      status_next = 8'h80;
      send_reg_next = 1'b0;
      send_pio_next = 1'b0;
      dl_stop = 1'b1; // [R3]
      state_next = ST_SRST;
    end else begin
      case (state_reg)
        ST_RESET: begin
          if (i_be_ready || dl_expired) begin
            // [R1] [R2] [R4]
            status_next = dl_expired ? 8'h41 : 8'h40;
            timeout_next = dl_expired;
            dl_stop = 1'b1;
            send_reg_next = 1'b1;
            state_next = ST_SEND;
          end
        end
        ST_SRST: begin
          if (i_srst_clr) begin
            dl_start = 1'b1; // [R4]
            state_next = ST_RESET;
          end
        end
        ST_IDLE: begin
          if (i_cmd) begin
            // busy is set by the host on sending; timing starts here
            status_next = 8'h80; // [R5]
            kind_next = i_cmd_kind;
            dl_limit = CMD_LIMIT[29:0] - MARGIN[29:0];
            dl_start = 1'b1;
            state_next = ST_WORK;
          end
        end
        ST_WORK: begin
          if (i_be_ready || dl_expired) begin
            dl_stop = 1'b1;
            timeout_next = dl_expired;
            if (kind_reg == `SSTM_KIND_NODATA || dl_expired) begin
              status_next = dl_expired ? 8'h41 : 8'h40; // [R6]
              send_reg_next = 1'b1;
            end else begin
              status_next = 8'h48; // [R7] [R10]
              send_pio_next = 1'b1;
            end
            state_next = ST_SEND;
          end
        end
        ST_SEND: begin
          if (i_send_ack) begin
            send_reg_next = 1'b0;
            send_pio_next = 1'b0;
            state_next = o_send_pio ? ST_XFER : ST_IDLE;
          end
        end
        ST_XFER: begin
          // host shows busy again after the setup or data frame
          if (kind_reg == `SSTM_KIND_PIO_IN || i_data_fis) begin
            status_next = 8'h80; // [R8] [R9]
            dl_limit = CMD_LIMIT[29:0] - MARGIN[29:0];
            dl_start = 1'b1;
            state_next = ST_WORK;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_RESET;
      kind_reg <= 2'h0;
      boot_reg <= 1'b1;
      o_status <= 8'h80;
      o_send_reg <= 1'b0;
      o_send_pio <= 1'b0;
      o_timeout <= 1'b0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      boot_reg <= 1'b0;
      o_status <= status_next;
      o_send_reg <= send_reg_next;
      o_send_pio <= send_pio_next;
      o_timeout <= timeout_next;
    end
  end
endmodule // sstm_monitor

/* shared/sstm_consts.vh */
/*
 * timing constants for the busy/data-request status timeout monitor.
 * assumes a 25 MHz core clock; included by bare name.
 */
`ifndef SSTM_CONSTS_VH
`define SSTM_CONSTS_VH

// ------------------------------------------------------------
// clock
// ------------------------------------------------------------
`define SSTM_CLK_HZ 25000000
`define SSTM_CLK_NS 40

// ------------------------------------------------------------
// limits in their own unit
// ------------------------------------------------------------
`define SSTM_RESET_LIMIT_SEC 31
`define SSTM_CMD_LIMIT_SEC 30
`define SSTM_HOST_LIMIT_NS 400

// ------------------------------------------------------------
// limits in cycles (host limit rounds down)
// ------------------------------------------------------------
`define SSTM_RESET_LIMIT_CYC (`SSTM_RESET_LIMIT_SEC * `SSTM_CLK_HZ)
`define SSTM_CMD_LIMIT_CYC (`SSTM_CMD_LIMIT_SEC * `SSTM_CLK_HZ)
`define SSTM_HOST_LIMIT_CYC (`SSTM_HOST_LIMIT_NS / `SSTM_CLK_NS)

// ------------------------------------------------------------
// status bit positions
// ------------------------------------------------------------
`define SSTM_ST_BUSY 7
`define SSTM_ST_READY 6
`define SSTM_ST_DREQ 3
`define SSTM_ST_ERR 0

// ------------------------------------------------------------
// command kinds
// ------------------------------------------------------------
`define SSTM_KIND_NODATA 2'h0
`define SSTM_KIND_PIO_IN 2'h1
`define SSTM_KIND_PIO_OUT 2'h2

`endif
